// File: rtl/bcc_regs.sv
// Input switch and channel configuration register bank with derived channel settings
`timescale 1ns/1ps
// Functional notes
// - Input invert bit 23 flips differential polarity when set; resets clear.
// - Positive isolate bit 21 disconnects positive input when set; resets set.
// - Negative isolate bit 20 disconnects negative input when set; resets set.
// - Family 00: rate codes 00,01,10 give 512,256,128 sps; 11 reserved; reset 10.
// - Family 01: rate codes 00,01,10 give 500,250,125 sps; 11 reserved.
// - Families 10/11: only code 10 valid, giving 200 or 199.8 sps.
// - Gain field codes 00..11 give 20,40,80,160 V/V; resets 00.
// - High-pass bit clear bypasses, set applies 0.50 Hz; resets set.
// - Low-pass code 00 only decimates at every rate.
// - Low-pass 01 near 40 Hz, 28.35/27.68 Hz at 128/125 sps; reset value.
// - Low-pass 10 near 100 Hz, only at 512, 256, 500, 250 sps.
// - Low-pass 11 near 150 Hz, only at 512 and 500 sps.
// - Unsupported low-pass acts as 01 and reads back as effective code.
// - Master frequency field bits 21:20 picks the sample-rate family.
module bcc_regs
   import bcc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [BUS_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [BUS_W-1:0] reg_rdata,
   output logic [1:0] master_freq_sel,
   output logic input_invert,
   output logic pos_input_isolate,
   output logic neg_input_isolate,
   output logic highpass_sel,
   output logic [1:0] gain_sel,
   output logic [7:0] gain_vv,
   output logic rate_valid,
   output logic [15:0] sample_rate_dsps,
   output logic [8:0] decim_ratio,
   output logic [1:0] lowpass_sel,
   output logic [15:0] lowpass_cutoff_chz,
   output logic config_changed
);
   // Stored fields
   logic [1:0] fm_q;
   logic invert_q;
   logic pos_iso_q;
   logic neg_iso_q;
   logic [1:0] rate_q;
   logic [1:0] gain_q;
   logic hpf_q;
   logic [1:0] lpf_q;
   // Derived, registered outputs
   logic [7:0] gain_vv_q;
   logic rate_valid_q;
   logic [15:0] sps_q;
   logic [8:0] decim_q;
   logic [1:0] lpf_eff_q;
   logic [15:0] cut_q;
   logic changed_q;
   logic [BUS_W-1:0] rdata_q;

   // Address decode
   wire logic hit_gen;
   wire logic hit_mux;
   wire logic hit_ch;
   wire logic wr_gen;
   wire logic wr_mux;
   wire logic wr_ch;

   assign hit_gen = (reg_addr == ADDR_GENERAL_CONFIG);
   assign hit_mux = (reg_addr == ADDR_INPUT_SWITCH_CONFIG);
   assign hit_ch = (reg_addr == ADDR_CHANNEL_CONFIG);
   assign wr_gen = reg_wr && hit_gen;
   assign wr_mux = reg_wr && hit_mux;
   assign wr_ch = reg_wr && hit_ch;

   // Combinational next values of the derived settings
   wire logic rv_d;
   wire logic [15:0] sps_d;
   wire logic [8:0] decim_d;
   wire logic [1:0] lpf_eff_d;
   wire logic [15:0] cut_d;
   wire logic [7:0] gain_vv_d;

   bcc_rate_decode u_rate (
      .master_freq_sel(fm_q),
      .rate_sel(rate_q),
      .rate_valid(rv_d),
      .sample_rate_dsps(sps_d),
      .decim_ratio(decim_d)
   );

   bcc_lowpass_map u_lowpass (
      .master_freq_sel(fm_q),
      .rate_sel(rate_q),
      .lowpass_written(lpf_q),
      .lowpass_eff(lpf_eff_d),
      .cutoff_chz(cut_d)
   );

   assign gain_vv_d = (gain_q == 2'h0) ? GAIN_20 :
                      (gain_q == 2'h1) ? GAIN_40 :
                      (gain_q == 2'h2) ? GAIN_80 : GAIN_160;

   // Read-back words; undefined bits are zero
   wire logic [BUS_W-1:0] rd_gen;
   wire logic [BUS_W-1:0] rd_mux;
   wire logic [BUS_W-1:0] rd_ch;
   wire logic [BUS_W-1:0] rd_word;

   assign rd_gen = {{(BUS_W-2){1'b0}}, fm_q} << POS_MASTER_FREQ_SEL;
   assign rd_mux = ({{(BUS_W-1){1'b0}}, invert_q} << POS_INPUT_INVERT)
                 | ({{(BUS_W-1){1'b0}}, pos_iso_q} << POS_POS_ISOLATE)
                 | ({{(BUS_W-1){1'b0}}, neg_iso_q} << POS_NEG_ISOLATE);
   // Low-pass reads the effective code, not the stored one
   assign rd_ch = ({{(BUS_W-2){1'b0}}, rate_q} << POS_RATE)
                | ({{(BUS_W-2){1'b0}}, gain_q} << POS_GAIN)
                | ({{(BUS_W-1){1'b0}}, hpf_q} << POS_HIGHPASS)
                | ({{(BUS_W-2){1'b0}}, lpf_eff_d} << POS_LOWPASS);
   // Unmapped addresses read zero
   assign rd_word = hit_gen ? rd_gen :
                    hit_mux ? rd_mux :
                    hit_ch ? rd_ch : {BUS_W{1'b0}};

   // General config: only the master frequency field lives here
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fm_q <= RST_MASTER_FREQ_SEL;
      end else if (wr_gen) begin
         fm_q <= reg_wdata[POS_MASTER_FREQ_SEL +: 2];
      end
   end

   // Input switch config
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         invert_q <= RST_INPUT_INVERT;
         pos_iso_q <= RST_POS_ISOLATE;
         neg_iso_q <= RST_NEG_ISOLATE;
      end else if (wr_mux) begin
         invert_q <= reg_wdata[POS_INPUT_INVERT];
         pos_iso_q <= reg_wdata[POS_POS_ISOLATE];
         neg_iso_q <= reg_wdata[POS_NEG_ISOLATE];
      end
   end

   // Channel config; the written low-pass code is kept as written
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rate_q <= RST_RATE;
         gain_q <= RST_GAIN;
         hpf_q <= RST_HIGHPASS;
         lpf_q <= RST_LOWPASS;
      end else if (wr_ch) begin
         rate_q <= reg_wdata[POS_RATE +: 2];
         gain_q <= reg_wdata[POS_GAIN +: 2];
         hpf_q <= reg_wdata[POS_HIGHPASS];
         lpf_q <= reg_wdata[POS_LOWPASS +: 2];
      end
   end

   // Derived settings trail the registers by one cycle; this keeps the
   // decode tables off the output pins at the cost of one cycle of latency
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         gain_vv_q <= GAIN_20;
         rate_valid_q <= 1'b1;
         sps_q <= SPS_128;
         decim_q <= DECIM_SLOW;
         lpf_eff_q <= RST_LOWPASS;
         cut_q <= CUT_28_35;
      end else begin
         gain_vv_q <= gain_vv_d;
         rate_valid_q <= rv_d;
         sps_q <= sps_d;
         decim_q <= decim_d;
         lpf_eff_q <= lpf_eff_d;
         cut_q <= cut_d;
      end
   end

   // Flags a possible data discontinuity after a channel config write
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         changed_q <= 1'b0;
      end else begin
         changed_q <= wr_ch;
      end
   end

   // Read data stand for exactly one cycle after the strobe
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata_q <= {BUS_W{1'b0}};
      end else begin
         rdata_q <= reg_rd ? rd_word : {BUS_W{1'b0}};
      end
   end

   assign reg_rdata = rdata_q;
   assign master_freq_sel = fm_q;
   assign input_invert = invert_q;
   assign pos_input_isolate = pos_iso_q;
   assign neg_input_isolate = neg_iso_q;
   assign highpass_sel = hpf_q;
   assign gain_sel = gain_q;
   assign gain_vv = gain_vv_q;
   assign rate_valid = rate_valid_q;
   assign sample_rate_dsps = sps_q;
   assign decim_ratio = decim_q;
   assign lowpass_sel = lpf_eff_q;
   assign lowpass_cutoff_chz = cut_q;
   assign config_changed = changed_q;
endmodule : bcc_regs

// File: inc/bcc_pkg.sv
// Package with register map, field layout, reset values and rate tables of the channel config
package bcc_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 24;
   localparam int BUS_W = 32;
   // Register indices; byte address is four times the index
   localparam logic [ADDR_W-1:0] IDX_GENERAL_CONFIG = 8'h10;
   localparam logic [ADDR_W-1:0] IDX_INPUT_SWITCH_CONFIG = 8'h14;
   localparam logic [ADDR_W-1:0] IDX_CHANNEL_CONFIG = 8'h15;
   localparam logic [ADDR_W-1:0] ADDR_GENERAL_CONFIG = IDX_GENERAL_CONFIG << 2;
   localparam logic [ADDR_W-1:0] ADDR_INPUT_SWITCH_CONFIG = IDX_INPUT_SWITCH_CONFIG << 2;
   localparam logic [ADDR_W-1:0] ADDR_CHANNEL_CONFIG = IDX_CHANNEL_CONFIG << 2;
   // Field positions
   localparam int POS_MASTER_FREQ_SEL = 20;
   localparam int POS_INPUT_INVERT = 23;
   localparam int POS_POS_ISOLATE = 21;
   localparam int POS_NEG_ISOLATE = 20;
   localparam int POS_RATE = 22;
   localparam int POS_GAIN = 16;
   localparam int POS_HIGHPASS = 14;
   localparam int POS_LOWPASS = 12;
   // Reset values
   localparam logic [1:0] RST_MASTER_FREQ_SEL = 2'h0;
   localparam logic RST_INPUT_INVERT = 1'b0;
   localparam logic RST_POS_ISOLATE = 1'b1;
   localparam logic RST_NEG_ISOLATE = 1'b1;
   localparam logic [1:0] RST_RATE = 2'h2;
   localparam logic [1:0] RST_GAIN = 2'h0;
   localparam logic RST_HIGHPASS = 1'b1;
   localparam logic [1:0] RST_LOWPASS = 2'h1;
   // Master frequency families
   localparam logic [1:0] FM_32768 = 2'h0;
   localparam logic [1:0] FM_32000_500 = 2'h1;
   localparam logic [1:0] FM_32000_200 = 2'h2;
   localparam logic [1:0] FM_31968 = 2'h3;
   // Low-pass codes
   localparam logic [1:0] LP_BYPASS = 2'h0;
   localparam logic [1:0] LP_40HZ = 2'h1;
   localparam logic [1:0] LP_100HZ = 2'h2;
   localparam logic [1:0] LP_150HZ = 2'h3;
   // Rate codes
   localparam logic [1:0] RATE_FAST = 2'h0;
   localparam logic [1:0] RATE_MID = 2'h1;
   localparam logic [1:0] RATE_SLOW = 2'h2;
   // Sample rates in tenths of a sample per second
   localparam logic [15:0] SPS_512 = 16'd5120;
   localparam logic [15:0] SPS_256 = 16'd2560;
   localparam logic [15:0] SPS_128 = 16'd1280;
   localparam logic [15:0] SPS_500 = 16'd5000;
   localparam logic [15:0] SPS_250 = 16'd2500;
   localparam logic [15:0] SPS_125 = 16'd1250;
   localparam logic [15:0] SPS_200 = 16'd2000;
   localparam logic [15:0] SPS_199_8 = 16'd1998;
   // Low-pass cutoffs in hundredths of a hertz
   localparam logic [15:0] CUT_40_96 = 16'd4096;
   localparam logic [15:0] CUT_102_4 = 16'd10240;
   localparam logic [15:0] CUT_153_6 = 16'd15360;
   localparam logic [15:0] CUT_28_35 = 16'd2835;
   localparam logic [15:0] CUT_40_00 = 16'd4000;
   localparam logic [15:0] CUT_100_0 = 16'd10000;
   localparam logic [15:0] CUT_150_0 = 16'd15000;
   localparam logic [15:0] CUT_27_68 = 16'd2768;
   localparam logic [15:0] CUT_39_96 = 16'd3996;
   localparam logic [15:0] CUT_NONE = 16'd0;
   // Gains in volts per volt
   localparam logic [7:0] GAIN_20 = 8'd20;
   localparam logic [7:0] GAIN_40 = 8'd40;
   localparam logic [7:0] GAIN_80 = 8'd80;
   localparam logic [7:0] GAIN_160 = 8'd160;
   // Master clock cycles per output sample (64, 128, 256, 160)
   localparam logic [8:0] DECIM_FAST = 9'h040;
   localparam logic [8:0] DECIM_MID = 9'h080;
   localparam logic [8:0] DECIM_SLOW = 9'h100;
   localparam logic [8:0] DECIM_200 = 9'h0a0;

   // True when the rate code is legal for the master frequency family
   function automatic logic bcc_rate_ok(input logic [1:0] fm, input logic [1:0] rate);
      bcc_rate_ok = (fm[1] == 1'b0) ? (rate != 2'h3) : (rate == RATE_SLOW);
   endfunction : bcc_rate_ok

   // True when the low-pass code is supported at this rate
   function automatic logic bcc_lp_ok(input logic [1:0] fm, input logic [1:0] rate,
                                      input logic [1:0] lp);
      logic fam512;
      fam512 = (fm[1] == 1'b0) && bcc_rate_ok(fm, rate);
      unique case (lp)
         LP_BYPASS: bcc_lp_ok = 1'b1;
         LP_40HZ: bcc_lp_ok = 1'b1;
         LP_100HZ: bcc_lp_ok = fam512 && (rate != RATE_SLOW);
         LP_150HZ: bcc_lp_ok = fam512 && (rate == RATE_FAST);
      endcase
   endfunction : bcc_lp_ok
endpackage : bcc_pkg

// File: rtl/bcc_rate_decode.sv
// Sample-rate decoder for the selected master frequency family
`timescale 1ns/1ps
module bcc_rate_decode
   import bcc_pkg::*;
(
   input wire logic [1:0] master_freq_sel,
   input wire logic [1:0] rate_sel,
   output logic rate_valid,
   output logic [15:0] sample_rate_dsps,
   output logic [8:0] decim_ratio
);
   wire logic [15:0] rate_fam0;
   wire logic [15:0] rate_fam1;

   assign rate_valid = bcc_rate_ok(master_freq_sel, rate_sel);
   assign rate_fam0 = (rate_sel == RATE_FAST) ? SPS_512 :
                      (rate_sel == RATE_MID) ? SPS_256 : SPS_128;
   assign rate_fam1 = (rate_sel == RATE_FAST) ? SPS_500 :
                      (rate_sel == RATE_MID) ? SPS_250 : SPS_125;
   // Reserved codes report a rate of zero
   assign sample_rate_dsps = !rate_valid ? 16'h0000 :
                             (master_freq_sel == FM_32768) ? rate_fam0 :
                             (master_freq_sel == FM_32000_500) ? rate_fam1 :
                             (master_freq_sel == FM_32000_200) ? SPS_200 : SPS_199_8;
   // Master clock cycles per output sample
   assign decim_ratio = !rate_valid ? 9'h000 :
                        master_freq_sel[1] ? DECIM_200 :
                        (rate_sel == RATE_FAST) ? DECIM_FAST :
                        (rate_sel == RATE_MID) ? DECIM_MID : DECIM_SLOW;
endmodule : bcc_rate_decode

// File: rtl/bcc_lowpass_map.sv
// Effective low-pass code and cutoff for the current rate
`timescale 1ns/1ps
module bcc_lowpass_map
   import bcc_pkg::*;
(
   input wire logic [1:0] master_freq_sel,
   input wire logic [1:0] rate_sel,
   input wire logic [1:0] lowpass_written,
   output logic [1:0] lowpass_eff,
   output logic [15:0] cutoff_chz
);
   wire logic slow;
   wire logic [15:0] cut40;
   wire logic [15:0] cut100;
   wire logic [15:0] cut150;

   // Unsupported settings fall back to the 40 Hz class
   assign lowpass_eff = bcc_lp_ok(master_freq_sel, rate_sel, lowpass_written) ?
                        lowpass_written : LP_40HZ;
   assign slow = (rate_sel == RATE_SLOW);
   assign cut40 = (master_freq_sel == FM_32768) ? (slow ? CUT_28_35 : CUT_40_96) :
                  (master_freq_sel == FM_32000_500) ? (slow ? CUT_27_68 : CUT_40_00) :
                  (master_freq_sel == FM_32000_200) ? CUT_40_00 : CUT_39_96;
   assign cut100 = (master_freq_sel == FM_32768) ? CUT_102_4 : CUT_100_0;
   assign cut150 = (master_freq_sel == FM_32768) ? CUT_153_6 : CUT_150_0;
   assign cutoff_chz = (lowpass_eff == LP_BYPASS) ? CUT_NONE :
                       (lowpass_eff == LP_40HZ) ? cut40 :
                       (lowpass_eff == LP_100HZ) ? cut100 : cut150;
endmodule : bcc_lowpass_map

// File: bench/bcc_regs_assertions.sv
// Concurrent checks on the channel config register bank ports
`timescale 1ns/1ps
module bcc_regs_chk
   import bcc_pkg::*;
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [BUS_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [BUS_W-1:0] reg_rdata,
   input wire logic [1:0] master_freq_sel,
   input wire logic input_invert,
   input wire logic pos_input_isolate,
   input wire logic neg_input_isolate,
   input wire logic highpass_sel,
   input wire logic [1:0] gain_sel,
   input wire logic [7:0] gain_vv,
   input wire logic rate_valid,
   input wire logic [15:0] sample_rate_dsps,
   input wire logic [8:0] decim_ratio,
   input wire logic [1:0] lowpass_sel,
   input wire logic [15:0] lowpass_cutoff_chz,
   input wire logic config_changed
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   wire logic wr_ch = reg_wr && (reg_addr == ADDR_CHANNEL_CONFIG);
   wire logic wr_sw = reg_wr && (reg_addr == ADDR_INPUT_SWITCH_CONFIG);
   sequence s_wr_ch;
      wr_ch;
   endsequence
   sequence s_wr_sw;
      wr_sw;
   endsequence
   property p_idle;
      !reg_rd |=> reg_rdata == 32'h0;
   endproperty
   property p_top;
      reg_rd |=> reg_rdata[31:24] == 8'h00;
   endproperty
   property p_inv;
      s_wr_sw |=> input_invert == $past(reg_wdata[POS_INPUT_INVERT]);
   endproperty
   property p_pos;
      s_wr_sw |=> pos_input_isolate == $past(reg_wdata[POS_POS_ISOLATE]);
   endproperty
   property p_neg;
      s_wr_sw |=> neg_input_isolate == $past(reg_wdata[POS_NEG_ISOLATE]);
   endproperty
   property p_gain;
      1'b1 |=> gain_vv == (GAIN_20 << $past(gain_sel));
   endproperty
   property p_hp;
      s_wr_ch |=> highpass_sel == $past(reg_wdata[POS_HIGHPASS]);
   endproperty
   property p_rate;
      s_wr_ch ##0 (master_freq_sel == FM_32768 && reg_wdata[23:22] == RATE_FAST)
         |=> ##1 sample_rate_dsps == SPS_512;
   endproperty
   property p_resv;
      s_wr_ch ##0 (master_freq_sel[1] && reg_wdata[23:22] != RATE_SLOW) |=> ##1 !rate_valid;
   endproperty
   property p_lp;
      s_wr_ch ##0 (master_freq_sel == FM_32768 && reg_wdata[23:22] == RATE_SLOW
         && reg_wdata[13:12] == LP_150HZ)
         |=> ##1 (lowpass_sel == LP_40HZ && lowpass_cutoff_chz == CUT_28_35);
   endproperty
   property p_chg;
      1'b1 |=> config_changed == $past(wr_ch);
   endproperty
   a_idle: assert property (p_idle) else $error("read data not zero when idle");
   a_top: assert property (p_top) else $error("read data top byte not zero");
   a_inv: assert property (p_inv) else $error("invert bit not taken");
   a_pos: assert property (p_pos) else $error("positive isolate not taken");
   a_neg: assert property (p_neg) else $error("negative isolate not taken");
   a_gain: assert property (p_gain) else $error("gain value wrong");
   a_hp: assert property (p_hp) else $error("high-pass bit not taken");
   a_rate: assert property (p_rate) else $error("fast rate wrong");
   a_resv: assert property (p_resv) else $error("reserved rate flagged valid");
   a_lp: assert property (p_lp) else $error("low-pass fallback wrong");
   a_chg: assert property (p_chg) else $error("change pulse wrong");
endmodule : bcc_regs_chk

bind bcc_regs bcc_regs_chk i_bcc_regs_chk (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .master_freq_sel(master_freq_sel), .input_invert(input_invert),
   .pos_input_isolate(pos_input_isolate), .neg_input_isolate(neg_input_isolate),
   .highpass_sel(highpass_sel), .gain_sel(gain_sel), .gain_vv(gain_vv),
   .rate_valid(rate_valid), .sample_rate_dsps(sample_rate_dsps), .decim_ratio(decim_ratio),
   .lowpass_sel(lowpass_sel), .lowpass_cutoff_chz(lowpass_cutoff_chz),
   .config_changed(config_changed));

// File: bench/bcc_regs_bench.sv
// Self-checking bench for the channel config register bank
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
   $display("BAD %0t got %h exp %h", $time, a, b); end end
module bcc_regs_bench
   import bcc_pkg::*;
;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [BUS_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [BUS_W-1:0] reg_rdata;
   logic [1:0] master_freq_sel, gain_sel, lowpass_sel;
   logic input_invert, pos_input_isolate, neg_input_isolate, highpass_sel;
   logic rate_valid, config_changed;
   logic [7:0] gain_vv;
   logic [15:0] sample_rate_dsps, lowpass_cutoff_chz;
   logic [8:0] decim_ratio;
   int err_total = 0;
   int comparisons = 0;
   // Reserved combinations expect zero rate
   logic [15:0] sps_tab [16] = '{SPS_512, SPS_256, SPS_128, 16'h0, SPS_500, SPS_250,
      SPS_125, 16'h0, 16'h0, 16'h0, SPS_200, 16'h0, 16'h0, 16'h0, SPS_199_8, 16'h0};
   logic [8:0] decim_tab [16] = '{DECIM_FAST, DECIM_MID, DECIM_SLOW, 9'h0, DECIM_FAST, DECIM_MID,
      DECIM_SLOW, 9'h0, 9'h0, 9'h0, DECIM_200, 9'h0, 9'h0, 9'h0, DECIM_200, 9'h0};

   bcc_regs i_bcc_regs (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .master_freq_sel(master_freq_sel), .input_invert(input_invert),
      .pos_input_isolate(pos_input_isolate), .neg_input_isolate(neg_input_isolate),
      .highpass_sel(highpass_sel), .gain_sel(gain_sel), .gain_vv(gain_vv),
      .rate_valid(rate_valid), .sample_rate_dsps(sample_rate_dsps),
      .decim_ratio(decim_ratio), .lowpass_sel(lowpass_sel),
      .lowpass_cutoff_chz(lowpass_cutoff_chz), .config_changed(config_changed));

   initial begin
      forever #10 clock = ~clock;
   end

   task automatic close_out();
      $display("Mismatches %0d comparisons %0d", err_total, comparisons);
      if (err_total == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : close_out

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data is only valid in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : rd

   // Write followed by a read in the very next cycle, no gap
   task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [BUS_W-1:0] d,
                        input logic [BUS_W-1:0] e);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask : wr_rd

   // Reset is driven on a clock edge like every other input
   task automatic do_reset(input int n);
      @(posedge clock);
      rst_b <= 1'b0;
      repeat (n - 1) @(posedge clock);
      rst_b <= 1'b1;
   endtask : do_reset

   task automatic chk_rst();
      rd(ADDR_INPUT_SWITCH_CONFIG, 32'h0030_0000);
      rd(ADDR_CHANNEL_CONFIG, 32'h0080_5000);
      `CHK({pos_input_isolate, neg_input_isolate, input_invert, highpass_sel}, 4'hd)
      `CHK(gain_vv, GAIN_20)
      `CHK(sample_rate_dsps, SPS_128)
      `CHK(lowpass_cutoff_chz, CUT_28_35)
      rd(ADDR_GENERAL_CONFIG, 32'h0);
      `CHK(master_freq_sel, RST_MASTER_FREQ_SEL)
      `CHK(gain_sel, RST_GAIN)
      `CHK({rate_valid, lowpass_sel, decim_ratio}, {1'b1, RST_LOWPASS, DECIM_SLOW})
      `CHK(config_changed, 1'b0)
   endtask : chk_rst

   function automatic logic [1:0] eff_lp(logic [1:0] f, logic [1:0] r, logic [1:0] l);
      if (l < LP_100HZ) return l;
      if (!f[1] && r != 2'h3 && (l == LP_100HZ ? r != RATE_SLOW : r == RATE_FAST)) return l;
      return LP_40HZ;
   endfunction : eff_lp

   function automatic logic [15:0] cut(logic [1:0] f, logic [1:0] r, logic [1:0] e);
      logic z;
      z = (f == FM_32768);
      case (e)
         LP_BYPASS: return CUT_NONE;
         LP_100HZ: return z ? CUT_102_4 : CUT_100_0;
         LP_150HZ: return z ? CUT_153_6 : CUT_150_0;
         default: begin
            if (f[1]) return f[0] ? CUT_39_96 : CUT_40_00;
            if (r == RATE_SLOW) return z ? CUT_28_35 : CUT_27_68;
            return z ? CUT_40_96 : CUT_40_00;
         end
      endcase
   endfunction : cut

   initial begin
      logic [1:0] f, r, l, e;
      do_reset(5);
      chk_rst();
      wr(ADDR_INPUT_SWITCH_CONFIG, 32'hffff_ffff);
      rd(ADDR_INPUT_SWITCH_CONFIG, 32'h00b0_0000);
      `CHK({input_invert, pos_input_isolate, neg_input_isolate}, 3'b111)
      wr(ADDR_INPUT_SWITCH_CONFIG, 32'h0010_0000);
      rd(ADDR_INPUT_SWITCH_CONFIG, 32'h0010_0000);
      `CHK({input_invert, pos_input_isolate, neg_input_isolate}, 3'b001)
      wr_rd(ADDR_INPUT_SWITCH_CONFIG, 32'h0080_0000, 32'h0080_0000);
      `CHK({input_invert, pos_input_isolate, neg_input_isolate}, 3'b100)
      wr(8'h58, 32'hffff_ffff);
      rd(8'h58, 32'h0);
      // Every family, rate and low-pass code; gain follows the low-pass index
      for (int i = 0; i < 64; i++) begin
         f = i[5:4];
         r = i[3:2];
         l = i[1:0];
         e = eff_lp(f, r, l);
         wr(ADDR_GENERAL_CONFIG, {10'h0, f, 20'h0});
         wr(ADDR_CHANNEL_CONFIG, {8'hff, r, 4'hf, l, 1'b1, r[0], l, 12'hfff});
         #1;
         `CHK(config_changed, 1'b1)
         rd(ADDR_GENERAL_CONFIG, {10'h0, f, 20'h0});
         rd(ADDR_CHANNEL_CONFIG, {8'h0, r, 4'h0, l, 1'b0, r[0], e, 12'h0});
         `CHK(sample_rate_dsps, sps_tab[{f, r}])
         `CHK(rate_valid, sps_tab[{f, r}] != 16'h0)
         `CHK(gain_vv, GAIN_20 << l)
         `CHK(gain_sel, l)
         `CHK(master_freq_sel, f)
         `CHK(decim_ratio, decim_tab[{f, r}])
         `CHK(highpass_sel, r[0])
         `CHK({lowpass_sel, lowpass_cutoff_chz}, {e, cut(f, r, e)})
      end
      do_reset(2);
      chk_rst();
      close_out();
   end

   // Loop needs under 1500 cycles
   initial begin
      repeat (10000) @(posedge clock);
      err_total++;
      close_out();
   end
endmodule : bcc_regs_bench
